// >>> adcct_regs.vh
`ifndef ADCCT_REGS_VH
`define ADCCT_REGS_VH
`define ADCCT_CONV_TICKS 18'h00014
`define ADCCT_CAL_FULL_TICKS 18'h3D0AA
`define ADCCT_CAL_DAC_TICKS 18'h36414
`define ADCCT_CAL_OFS_TICKS 18'h06C96
`define ADCCT_CAL_FULL 2'h0
`define ADCCT_CAL_DAC 2'h1
`define ADCCT_CAL_OFS 2'h2
`define ADCCT_MODE_INT_LO 3'h4
`define ADCCT_FRAME_BITS 5'h10
`define ADCCT_LAST_BIT 5'h0F
`define ADCCT_CNT_W 18
`define ADCCT_FIFO_DEPTH 8
`define ADCCT_FIFO_AW 3
`endif

// >>> adcct_core.v
`timescale 1ns/1ps
`default_nettype none
`include "adcct_regs.vh"

module adcct_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = `ADCCT_FIFO_DEPTH,
    parameter AW = `ADCCT_FIFO_AW
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push;
    wire pop;
    assign in_ready = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // adcct_fifo

module adcct_core #(
    parameter DATA_W = 14,
    parameter WORD_W = 16,
    parameter [`ADCCT_CNT_W-1:0] CAL_FULL_TICKS = `ADCCT_CAL_FULL_TICKS,
    parameter [`ADCCT_CNT_W-1:0] CAL_DAC_TICKS = `ADCCT_CAL_DAC_TICKS,
    parameter [`ADCCT_CNT_W-1:0] CAL_OFS_TICKS = `ADCCT_CAL_OFS_TICKS
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // converter control pins
    input wire master_clock_in,
    input wire conversion_start_n,
    input wire cal_start,
    input wire [1:0] cal_type,
    output reg busy,
    // converter result from the analog side
    input wire [DATA_W-1:0] sample_data,
    // serial port configuration
    input wire [2:0] interface_mode,
    input wire polarity,
    input wire din_shared,
    // serial link
    input wire frame_sel_n,
    input wire sclk_in,
    output reg sclk_out,
    output wire sclk_oe_n,
    output wire dout,
    output wire dout_oe_n,
    input wire din_in,
    output wire din_out,
    output reg din_oe_n,
    // received words
    output reg [WORD_W-1:0] rx_word,
    output reg rx_valid
);
    localparam ST_IDLE = 2'h0;
    localparam ST_CONV = 2'h1;
    localparam ST_CAL = 2'h2;

    // two-flop synchronisers for the master clock, start, calibrate, frame, serial clock and data-in pins
    reg [1:0] mclk_s;
    reg [1:0] cs_s;
    reg [1:0] cal_s;
    reg [1:0] fs_s;
    reg [1:0] sck_s;
    reg [1:0] din_s;
    reg mclk_d;
    reg cs_d;
    reg cal_d;
    reg fs_d;
    reg sck_eff_d;
    wire sck_eff;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            mclk_s <= 2'h0;
            cs_s <= 2'h3;
            cal_s <= 2'h0;
            fs_s <= 2'h3;
            sck_s <= 2'h0;
            din_s <= 2'h0;
            mclk_d <= 1'b0;
            cs_d <= 1'b1;
            cal_d <= 1'b0;
            fs_d <= 1'b1;
            sck_eff_d <= 1'b0;
        end else begin
            mclk_s <= {mclk_s[0], master_clock_in};
            cs_s <= {cs_s[0], conversion_start_n};
            cal_s <= {cal_s[0], cal_start};
            fs_s <= {fs_s[0], frame_sel_n};
            sck_s <= {sck_s[0], sclk_in};
            din_s <= {din_s[0], din_in};
            mclk_d <= mclk_s[1];
            cs_d <= cs_s[1];
            cal_d <= cal_s[1];
            fs_d <= fs_s[1];
            sck_eff_d <= sck_eff;
        end
    end
    wire mclk_tick = mclk_s[1] && !mclk_d;
    wire cs_fall = cs_d && !cs_s[1];
    wire cal_rise = cal_s[1] && !cal_d;
    wire fs_fall = fs_d && !fs_s[1];
    wire frame_on = !fs_s[1];

    // conversion and calibration sequencer
    reg [1:0] state;
    reg [`ADCCT_CNT_W-1:0] ticks;
    wire fifo_in_ready;
    reg push;
    function [`ADCCT_CNT_W-1:0] cal_len;
        input [1:0] kind;
        begin
            case (kind)
                `ADCCT_CAL_DAC: cal_len = CAL_DAC_TICKS;
                `ADCCT_CAL_OFS: cal_len = CAL_OFS_TICKS;
                default: cal_len = CAL_FULL_TICKS;
            endcase
        end
    endfunction
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            ticks <= {`ADCCT_CNT_W{1'b0}};
            busy <= 1'b0;
            push <= 1'b0;
        end else begin
            push <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (cal_rise) begin
                        state <= ST_CAL;
                        ticks <= cal_len(cal_type);
                        busy <= 1'b1;
                    end else if (cs_fall && fifo_in_ready) begin
                        // a full buffer refuses new conversions so no result is lost
                        state <= ST_CONV;
                        ticks <= `ADCCT_CONV_TICKS;
                        busy <= 1'b1;
                    end
                end
                ST_CONV, ST_CAL: begin
                    if (state == ST_CAL && cs_fall) begin
                        busy <= 1'b1;
                    end
                    if (mclk_tick) begin
                        if (ticks == {{(`ADCCT_CNT_W-1){1'b0}}, 1'b1}) begin
                            state <= ST_IDLE;
                            busy <= 1'b0;
                            push <= (state == ST_CONV);
                        end
                        ticks <= ticks - 1'b1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    busy <= 1'b0;
                end
            endcase
        end
    end

    // result buffer between converter and serial port
    wire fifo_out_valid;
    wire [WORD_W-1:0] fifo_out_data;
    wire pop = fs_fall && fifo_out_valid;
    adcct_fifo #(.WIDTH(WORD_W), .DEPTH(`ADCCT_FIFO_DEPTH), .AW(`ADCCT_FIFO_AW)) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data({{(WORD_W-DATA_W){1'b0}}, sample_data}),
        .out_valid(fifo_out_valid),
        .out_ready(pop),
        .out_data(fifo_out_data)
    );

    // serial clock source and edge selection
    wire int_clk = (interface_mode >= `ADCCT_MODE_INT_LO);
    wire sck_lvl = int_clk ? sclk_out : sck_s[1];
    assign sck_eff = sck_lvl ~^ polarity;
    wire sck_rise = sck_eff && !sck_eff_d;
    wire sck_fall = !sck_eff && sck_eff_d;
    assign sclk_oe_n = !int_clk;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_out <= 1'b0;
        end else begin
            // follows the master clock so high and low phases stay near half
            sclk_out <= mclk_s[1];
        end
    end

    // frame shifter
    reg [WORD_W-1:0] tx_sr;
    reg [WORD_W-1:0] rx_sr;
    reg [4:0] rx_cnt;
    reg started;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_sr <= {WORD_W{1'b0}};
            rx_sr <= {WORD_W{1'b0}};
            rx_cnt <= 5'h00;
            rx_word <= {WORD_W{1'b0}};
            rx_valid <= 1'b0;
            din_oe_n <= 1'b1;
            started <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            if (fs_fall) begin
                tx_sr <= fifo_out_valid ? fifo_out_data : {WORD_W{1'b0}};
                rx_cnt <= 5'h00;
                started <= 1'b0;
            end else if (!frame_on) begin
                din_oe_n <= 1'b1;
            end else begin
                if (sck_fall && started) begin
                    tx_sr <= {tx_sr[WORD_W-2:0], 1'b0};
                end
                if (sck_rise && rx_cnt != `ADCCT_FRAME_BITS) begin
                    started <= 1'b1;
                    rx_sr <= {rx_sr[WORD_W-2:0], din_s[1]};
                    rx_cnt <= rx_cnt + 1'b1;
                    if (din_shared && rx_cnt == 5'h00) begin
                        din_oe_n <= 1'b0;
                    end
                    if (rx_cnt == `ADCCT_LAST_BIT) begin
                        // host may drive the line only after this release
                        din_oe_n <= 1'b1;
                        rx_word <= {rx_sr[WORD_W-2:0], din_s[1]};
                        rx_valid <= !din_shared;
                    end
                end
            end
        end
    end
    assign dout = tx_sr[WORD_W-1];
    assign dout_oe_n = !frame_on || din_shared;
    assign din_out = tx_sr[WORD_W-1];
endmodule // adcct_core
`default_nettype wire

// >>> adcct_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcct_regs.vh"
module adcct_checker #(
    parameter [`ADCCT_CNT_W-1:0] CAL_FULL_TICKS = `ADCCT_CAL_FULL_TICKS,
    parameter [`ADCCT_CNT_W-1:0] CAL_DAC_TICKS = `ADCCT_CAL_DAC_TICKS,
    parameter [`ADCCT_CNT_W-1:0] CAL_OFS_TICKS = `ADCCT_CAL_OFS_TICKS
) (
    // sequencer
    input wire logic clk,
    input wire logic rst,
    input wire logic master_clock_in,
    input wire logic conversion_start_n,
    input wire logic cal_start,
    input wire logic busy,
    input wire logic [1:0] cal_type,
    // serial port
    input wire logic [2:0] interface_mode,
    input wire logic din_shared,
    input wire logic frame_sel_n,
    input wire logic sclk_out,
    input wire logic sclk_oe_n,
    input wire logic dout_oe_n,
    input wire logic din_oe_n
);
    logic mc_q;
    logic [3:0] words;
    logic [`ADCCT_CNT_W-1:0] mcnt, need;
    // ticks seen here lead the design's synchroniser, so counts may differ by one
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            mc_q <= 1'b0;
            words <= 4'h0;
            mcnt <= '0;
            need <= `ADCCT_CONV_TICKS;
        end else begin
            mc_q <= master_clock_in;
            mcnt <= busy ? mcnt + (master_clock_in & ~mc_q) : '0;
            if ($rose(busy))
                need <= !cal_start ? `ADCCT_CONV_TICKS : cal_type == `ADCCT_CAL_DAC ?
                    CAL_DAC_TICKS : cal_type == `ADCCT_CAL_OFS ? CAL_OFS_TICKS : CAL_FULL_TICKS;
            words <= words + 4'(($fell(busy) && need == `ADCCT_CONV_TICKS))
                - 4'(($fell(frame_sel_n) && words != 4'h0));
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_busy_cause: assert property ($rose(busy) |->
        !$past(conversion_start_n) || $past(cal_start)) else $error("busy rose unprompted");
    a_conv_starts: assert property ($fell(conversion_start_n) && !busy && !cal_start
        && words < 4'h8 |-> ##[1:5] busy) else $error("busy missing after start");
    a_busy_short: assert property ($fell(busy) |-> mcnt <= need + 1)
        else $error("busy too long");
    a_busy_long: assert property ($fell(busy) |-> mcnt + 1 >= need)
        else $error("busy too short");
    a_sclk_dir: assert property (sclk_oe_n == (interface_mode < 3'h4))
        else $error("serial clock direction wrong");
    a_sclk_follow: assert property (interface_mode >= 3'h4 && $rose(master_clock_in)
        |-> ##[1:4] $rose(sclk_out)) else $error("serial clock not following master");
    a_dout_drive: assert property ($fell(frame_sel_n) && !din_shared
        |-> ##[1:5] !dout_oe_n) else $error("data out not driven");
    a_dout_release: assert property ($rose(frame_sel_n) |-> ##[1:5] dout_oe_n)
        else $error("data out not released");
    a_din_owner: assert property (!din_oe_n |-> din_shared && dout_oe_n)
        else $error("shared line driven wrongly");
endmodule // adcct_checker
bind adcct_core adcct_checker #(.CAL_FULL_TICKS(CAL_FULL_TICKS), .CAL_DAC_TICKS(CAL_DAC_TICKS),
    .CAL_OFS_TICKS(CAL_OFS_TICKS)) u_chk (.clk, .rst, .master_clock_in, .conversion_start_n,
    .cal_start, .busy, .cal_type, .interface_mode, .din_shared, .frame_sel_n, .sclk_out,
    .sclk_oe_n, .dout_oe_n, .din_oe_n);
`default_nettype wire

// >>> adcct_host.sv
`timescale 1ns/1ps
`default_nettype none
module adcct_host (
    // link
    output logic sclk_in,
    output logic frame_sel_n,
    output wire logic din_in,
    input wire logic dout,
    input wire logic dout_oe_n,
    input wire logic din_out,
    input wire logic din_oe_n,
    input wire logic polarity,
    input wire logic din_shared,
    // received word
    output logic got,
    output logic [15:0] got_w
);
    logic raw = 1'b0;
    logic hd = 1'b1;
    logic lv = 1'b0;
    initial frame_sel_n = 1'b1;
    initial got = 1'b0;
    assign sclk_in = raw ^ !polarity;
    assign din_in = din_oe_n ? hd : din_out;
    // clock stands still between frames
    task automatic frame(input logic [15:0] w);
        logic [15:0] r;
        #17 frame_sel_n = 1'b0;
        #400;
        for (int i = 15; i >= 0; i--) begin
            hd = w[i];
            #200 raw = 1'b1;
            lv = din_shared ? din_in : (dout_oe_n ? ~lv : dout);
            r = {r[14:0], lv};
            #200 raw = 1'b0;
        end
        #200 frame_sel_n = 1'b1;
        hd = ~hd;
        if (!din_shared) begin
            got_w = r;
            got = 1'b1;
            #50 got = 1'b0;
        end
    endtask
endmodule // adcct_host
`default_nettype wire

// >>> test_adc_conversion_calibration_serial_timing.sv
`timescale 1ns/1ps
`default_nettype none
module test_adc_conversion_calibration_serial_timing;
    logic clk = 1'b0, rst = 1'b1, master_clock_in = 1'b0, conversion_start_n = 1'b1;
    logic cal_start = 1'b0, polarity = 1'b1, din_shared = 1'b0, got;
    logic [1:0] cal_type = 2'h0;
    logic [2:0] interface_mode = 3'h0;
    logic [13:0] sample_data = 14'h0000;
    logic busy, sclk_in, frame_sel_n, sclk_out, sclk_oe_n, dout, dout_oe_n, din_in, din_out;
    logic din_oe_n, rx_valid;
    logic [15:0] rx_word, got_w, w;
    logic [15:0] q_rx[$], q_tx[$];
    int err_total = 0, comparisons = 0;
    always #25 clk = ~clk;
    always #100 master_clock_in = ~master_clock_in;
    adcct_core #(.CAL_FULL_TICKS(18'h00028), .CAL_DAC_TICKS(18'h0001E),
        .CAL_OFS_TICKS(18'h00018)) DUT (.clk, .rst, .master_clock_in, .conversion_start_n,
        .cal_start, .cal_type, .busy, .sample_data, .interface_mode, .polarity, .din_shared,
        .frame_sel_n, .sclk_in, .sclk_out, .sclk_oe_n, .dout, .dout_oe_n, .din_in, .din_out,
        .din_oe_n, .rx_word, .rx_valid);
    adcct_host host (.sclk_in, .frame_sel_n, .din_in, .dout, .dout_oe_n, .din_out, .din_oe_n,
        .polarity, .din_shared, .got, .got_w);
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check(input string nm, input logic [15:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wait_busy(input logic v);
        for (int k = 0; k < 400 && busy !== v; k++) step(1);
        check("busy", busy, v);
    endtask
    task automatic start_pulse;
        conversion_start_n = 1'b0;
        step(6);
        conversion_start_n = 1'b1;
    endtask
    task automatic wrap_up;
        $display("err_total %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // mid-cycle look: the one-cycle pulse is seen once, away from the edge that moves it
    always @(negedge clk) if (rx_valid === 1'b1) check("rx", rx_word, q_rx.pop_front());
    always @(posedge got) check("tx", got_w, q_tx.pop_front());
    initial begin
        #1000000;
        err_total++;
        wrap_up();
    end
    initial begin
        void'($urandom(92));
        step(6);
        rst = 1'b0;
        step(4);
        for (int t = 0; t < 4; t++) begin
            cal_type = t[1:0];
            cal_start = 1'b1;
            step(6);
            cal_start = 1'b0;
            start_pulse();
            check("cal busy", busy, 1'b1);
            wait_busy(1'b0);
        end
        // ninth start finds the buffer full and is dropped
        for (int i = 0; i < 9; i++) begin
            sample_data = 14'($urandom);
            start_pulse();
            check("conv busy", busy, i < 8);
            wait_busy(1'b0);
            if (i < 8) q_tx.push_back({2'h0, sample_data});
            // result is written one cycle after busy falls: hold the sample past it
            step(2);
        end
        q_tx.push_back(16'h0000);
        for (int i = 0; i < 10; i++) begin
            polarity = i[0];
            interface_mode = 3'($urandom_range(3));
            din_shared = i == 9;
            w = 16'($urandom);
            if (i < 9) q_rx.push_back(w);
            step(4);
            host.frame(w);
            step(8);
        end
        interface_mode = 3'h5;
        step(20);
        check("sclk oe", sclk_oe_n, 1'b0);
        check("rx left", 16'(q_rx.size()), 16'h0000);
        check("tx left", 16'(q_tx.size()), 16'h0000);
        wrap_up();
    end
endmodule // test_adc_conversion_calibration_serial_timing
`default_nettype wire
